//--- engine_seq.sv
// Purpose: engine start/stop sequencer with speed and charge supervision
// Assumes: inputs synchronous to ref_clk_in; speed in rpm, charge in 0.1 V
// Notes: one packed state struct, one comb fill, one register stage
// Functional notes
// - speed limits scale from nominal 1, 2 or 3 chosen by frequency select
// - on load: low warning below low warn, shutdown below low shutdown
// - on load: high warning above high warn, shutdown above high shutdown
// - speed fault only after out of limits for speed-fail time, 0..10 s
// - above high shutdown plus overshoot: immediate shutdown and stop
// - one enable bit decides whether speed signal loss is supervised
// - loss response: 0 shutdown, 1 load dump, 2 warning
// - loss declared only after absent for loss timer, up to 240 s
// - charge below warn limit warns, below shutdown limit stops engine
// - charge fault only after low for charge timer, default 1 s
// - after mains failure wait start delay minutes before fuel on
// - preheat held for preheat time after fuel on, before cranking
// - crank lasts at most crank time, ends early once running
// - pause wait time between crank attempts
// - load held off until heating done, by time or time plus coolant
// - after mains returns, run unloaded for cooldown time, then stop
// - stop output energized for stop-solenoid time when stopping
// - engine still running at end of stop period raises stop warning
// - choke asserted together with crank
// - choke released on choke delay expiry or engine running
// - engine running when speed reaches crank-cut speed; crank dropped
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`default_nettype none
`include "engine_seq_cfg.svh"
module engine_seq
  import engine_seq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic mains_fail_in,
  input wire logic [1:0] freq_sel_in,
  input wire sense_type sense_in,
  output relay_type relay_out,
  output alarm_type alarm_out
);
  // ****************************************
  // state
  // ****************************************
  localparam logic [9:0][31:0] REG_RST = {
    `RST_CUT, `RST_STOP, `RST_RUN, `RST_START, `RST_CHG,
    `RST_SPD, `RST_LIM, `RST_NOM3, `RST_NOM2, `RST_NOM1
  };
  core_type r;
  core_type n;
  seq_state_type nst;
  logic tick;
  logic running;
  logic supervise;
  logic feeding;
  logic [15:0] ref_rpm;
  logic [23:0] spd100;
  logic lo_w, lo_s, hi_w, hi_s, os_hit;
  logic spd_due, loss_due, chg_due;
  logic lost, chg_lo, chg_low_sd;
  logic sd_ev, dump_ev, lock;
  logic [8:0] os_pct;
  logic [15:0] dly_lim;
  logic [3:0] idx;
  logic hit;
  alarm_type set;
  // events raised by the sequencer itself; kept apart from set so each has one driver
  logic start_fail_ev;
  logic stop_warn_ev;

  // ****************************************
  // configuration views
  // ****************************************
  // selected nominal speed
  always_comb begin
    unique case (freq_sel_in)
      2'h1: ref_rpm = r.regs[`R_NOM2][`F_RPM];
      2'h2: ref_rpm = r.regs[`R_NOM3][`F_RPM];
      default: ref_rpm = r.regs[`R_NOM1][`F_RPM];
    endcase
  end

  // limits are percent of nominal; cross-multiplied to avoid a divider
  assign spd100 = 24'(sense_in.rpm) * `PCT_SCALE;
  assign os_pct = 9'(r.regs[`R_LIM][`F_HS]) + 9'(r.regs[`R_SPD][`F_OS]);
  assign lo_w = spd100 < 24'(ref_rpm) * 24'(r.regs[`R_LIM][`F_LW]);
  assign lo_s = spd100 < 24'(ref_rpm) * 24'(r.regs[`R_LIM][`F_LS]);
  assign hi_w = spd100 > 24'(ref_rpm) * 24'(r.regs[`R_LIM][`F_HW]);
  assign hi_s = spd100 > 24'(ref_rpm) * 24'(r.regs[`R_LIM][`F_HS]);
  assign os_hit = 25'(spd100) > 25'(ref_rpm) * 25'(os_pct);

  // engine running once crank-cut speed reached
  assign running = sense_in.rpm >= r.regs[`R_CUT][`F_RPM];
  assign feeding = r.st == S_LOADED;
  assign supervise = r.st inside {S_HEAT, S_LOADED, S_COOL};
  assign tick = r.div == 32'(TICK_CYCLES - 1);

  // fault conditions qualified by their own timers
  assign lost = supervise && r.regs[`R_SPD][`F_LOSS_EN] && !sense_in.sig_ok;
  assign chg_lo = supervise && sense_in.charge_dv < r.regs[`R_CHG][`F_CHG_W];
  assign chg_low_sd = sense_in.charge_dv < r.regs[`R_CHG][`F_CHG_S];
  assign spd_due = feeding && (lo_w || hi_w) &&
    r.spd_t >= r.regs[`R_SPD][`F_SPD_FAIL];
  assign loss_due = lost && r.loss_t >= r.regs[`R_SPD][`F_LOSS_T];
  assign chg_due = chg_lo && r.chg_t >= r.regs[`R_CHG][`F_CHG_T];

  // alarm events this cycle
  always_comb begin
    set = '0;
    set.lo_warn = spd_due && lo_w;
    set.lo_sd = spd_due && lo_s;
    set.hi_warn = spd_due && hi_w;
    set.hi_sd = (spd_due && hi_s) || (feeding && os_hit);
    set.sig_lost = loss_due;
    set.sig_dump = loss_due && r.regs[`R_SPD][`F_LOSS_ACT] == `LOSS_DUMP;
    set.chg_warn = chg_due;
    set.chg_sd = chg_due && chg_low_sd;
  end
  assign sd_ev = set.lo_sd || set.hi_sd || set.chg_sd ||
    (loss_due && r.regs[`R_SPD][`F_LOSS_ACT] == `LOSS_SD);
  assign dump_ev = set.sig_dump;
  // a pending shutdown or start failure blocks a new start until cleared
  assign lock = r.alm.lo_sd || r.alm.hi_sd || r.alm.chg_sd ||
    r.alm.start_fail || (r.alm.sig_lost && !r.alm.sig_dump &&
    r.regs[`R_SPD][`F_LOSS_ACT] == `LOSS_SD);
  assign dly_lim = 16'(r.regs[`R_START][`F_DLY_MIN]) * `SEC_PER_MIN;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = r;
    nst = r.st;
    idx = addr_in[5:2];
    hit = addr_in[1:0] == 2'h0 && addr_in[7:6] == 2'h0;
    n.rdata = 32'h00000000;
    start_fail_ev = 1'b0;
    stop_warn_ev = 1'b0;
    // one-second tick divider
    n.div = tick ? 32'h00000000 : r.div + 32'h00000001;
    if (tick && r.tmr != 16'hffff) begin
      n.tmr = r.tmr + 16'h0001;
    end
    // supervision timers restart as soon as the condition clears
    if (!(feeding && (lo_w || hi_w))) begin
      n.spd_t = 4'h0;
    end else if (tick && r.spd_t != 4'hf) begin
      n.spd_t = r.spd_t + 4'h1;
    end
    if (!lost) begin
      n.loss_t = 8'h00;
    end else if (tick && r.loss_t != 8'hff) begin
      n.loss_t = r.loss_t + 8'h01;
    end
    if (!chg_lo) begin
      n.chg_t = 7'h00;
    end else if (tick && r.chg_t != 7'h7f) begin
      n.chg_t = r.chg_t + 7'h01;
    end
    // choke runs its own delay from crank start
    if (r.choke) begin
      if (tick) begin
        n.chk = r.chk + 8'h01;
      end
      if (running || r.chk >= r.regs[`R_RUN][`F_CHOKE] ||
          !(r.st inside {S_CRANK, S_WAIT})) begin
        n.choke = 1'b0;
      end
    end
    // sequencer
    unique case (r.st)
      S_IDLE: begin
        if (mains_fail_in && !lock) begin
          nst = S_DELAY;
        end
      end
      S_DELAY: begin
        if (!mains_fail_in) begin
          nst = S_IDLE; // short outage never starts the engine
        end else if (r.tmr >= dly_lim) begin
          nst = S_PREHEAT;
          n.att = 3'h0;
        end
      end
      S_PREHEAT: begin
        if (!mains_fail_in) begin
          nst = S_STOP;
        end else if (r.tmr >= 16'(r.regs[`R_START][`F_PREHEAT])) begin
          nst = S_CRANK;
        end
      end
      S_CRANK: begin
        if (running) begin
          nst = S_HEAT;
        end else if (!mains_fail_in) begin
          nst = S_STOP;
        end else if (r.tmr >= 16'(r.regs[`R_START][`F_CRANK])) begin
          if (r.att >= r.regs[`R_START][`F_NSTART]) begin
            nst = S_STOP;
            start_fail_ev = 1'b1;
          end else begin
            nst = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (!mains_fail_in) begin
          nst = S_STOP;
        end else if (r.tmr >= 16'(r.regs[`R_START][`F_WAIT])) begin
          nst = S_CRANK;
        end
      end
      S_HEAT: begin
        if (!mains_fail_in) begin
          nst = S_COOL;
        end else if (r.tmr >= 16'(r.regs[`R_RUN][`F_HEAT_T]) &&
            (!r.regs[`R_RUN][`F_HEAT_M] ||
            sense_in.coolant_c >= 8'(r.regs[`R_RUN][`F_HEAT_C]))) begin
          nst = S_LOADED;
        end
      end
      S_LOADED: begin
        if (!mains_fail_in) begin
          nst = S_COOL;
        end
      end
      S_COOL: begin
        if (mains_fail_in && !dump_ev && !r.alm.sig_dump) begin
          nst = S_LOADED;
        end else if (r.tmr >= 16'(r.regs[`R_STOP][`F_COOL])) begin
          nst = S_STOP;
        end
      end
      S_STOP: begin
        if (r.tmr >= 16'(r.regs[`R_STOP][`F_STOP_T])) begin
          nst = S_IDLE;
          stop_warn_ev = running;
        end
      end
    endcase
    // alarms override the normal sequence
    if (sd_ev && supervise) begin
      nst = S_STOP;
    end else if (dump_ev && r.st inside {S_HEAT, S_LOADED}) begin
      nst = S_COOL;
    end
    // every crank entry counts an attempt and starts the choke
    if (nst == S_CRANK && r.st != S_CRANK) begin
      n.att = r.att + 3'h1;
      n.choke = 1'b1;
      n.chk = 8'h00;
    end
    if (nst != r.st) begin
      n.tmr = 16'h0000;
    end
    n.st = nst;
    // register port: writes, then sticky flags with set winning
    if (wr_in && hit && idx < 4'(`N_CFG)) begin
      n.regs[idx] = wdata_in;
    end
    n.alm = r.alm;
    if (wr_in && hit && idx == `R_ALM) begin
      n.alm = r.alm & ~alarm_type'(wdata_in[9:0]);
    end
    n.alm = n.alm | set;
    n.alm.start_fail = n.alm.start_fail | start_fail_ev;
    n.alm.stop_failure_warning = n.alm.stop_failure_warning | stop_warn_ev;
    if (rd_in && hit) begin
      if (idx < 4'(`N_CFG)) begin
        n.rdata = r.regs[idx];
      end else if (idx == `R_STAT) begin
        n.rdata = {20'h00000, lock, running, r.choke, r.att, 2'h0, r.st};
      end else if (idx == `R_ALM) begin
        n.rdata = {22'h000000, r.alm};
      end
    end
  end

  // ****************************************
  // register stage
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r <= '{st: S_IDLE, regs: REG_RST, default: '0};
    end else begin
      r <= n;
    end
  end

  // relays decode the registered phase; choke follows its own registered flag
  assign relay_out.fuel = r.st inside {S_PREHEAT, S_CRANK, S_WAIT, S_HEAT, S_LOADED, S_COOL};
  assign relay_out.preheat = r.st == S_PREHEAT;
  assign relay_out.crank = r.st == S_CRANK;
  assign relay_out.choke = r.choke;
  assign relay_out.stop = r.st == S_STOP;
  assign relay_out.load = r.st == S_LOADED;
  assign alarm_out = r.alm;
  assign rdata_out = r.rdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_crank_timeout;
    r.st == S_CRANK && !running && mains_fail_in &&
      r.tmr >= 16'(r.regs[`R_START][`F_CRANK]);
  endsequence
  sequence s_stop_end;
    r.st == S_STOP && r.tmr >= 16'(r.regs[`R_STOP][`F_STOP_T]);
  endsequence

  a_choke_with_crank: assert property ($rose(relay_out.crank) |-> relay_out.choke)
    else $error("choke not raised with crank");
  a_crank_cut_run: assert property (relay_out.crank && running |=> !relay_out.crank)
    else $error("crank kept after engine running");
  a_overshoot_stop: assert property (feeding && os_hit |=> r.st == S_STOP && r.alm.hi_sd)
    else $error("overshoot did not stop engine");
  a_start_delay_done: assert property ($rose(relay_out.fuel) |->
    $past(r.st) == S_DELAY && $past(r.tmr) >= $past(dly_lim))
    else $error("fuel on before start delay");
  a_crank_attempts: assert property (relay_out.crank |->
    r.att != 3'h0 && r.att <= r.regs[`R_START][`F_NSTART])
    else $error("crank attempt count out of range");
  a_crank_limit: assert property (s_crank_timeout |=> r.st inside {S_WAIT, S_STOP})
    else $error("crank exceeded crank time");
  a_stop_fail_flag: assert property (s_stop_end ##0 running |=>
    r.alm.stop_failure_warning && r.st == S_IDLE)
    else $error("stop failure not flagged");
  a_loss_ignored: assert property (!r.regs[`R_SPD][`F_LOSS_EN] |-> !loss_due)
    else $error("signal loss seen while disabled");
  a_load_after_heat: assert property ($rose(relay_out.load) && $past(r.st) == S_HEAT |->
    $past(r.tmr) >= 16'($past(r.regs[`R_RUN][`F_HEAT_T])))
    else $error("load taken before heating time");
  a_cooldown_first: assert property (feeding && !mains_fail_in && !sd_ev |=>
    r.st == S_COOL && !relay_out.stop)
    else $error("no cooldown after mains return");
  // a load dump drops the load but keeps the engine turning through cooldown
  a_loss_dump_cool: assert property (
    loss_due && !sd_ev && r.regs[`R_SPD][`F_LOSS_ACT] == `LOSS_DUMP &&
    r.st inside {S_HEAT, S_LOADED} |=> r.st == S_COOL && r.alm.sig_dump)
    else $error("load dump did not enter cooldown");
  // charge below the shutdown limit for the fail time stops the engine
  a_charge_stop: assert property (
    chg_due && chg_low_sd |=> r.st == S_STOP && r.alm.chg_sd)
    else $error("charge shutdown did not stop engine");
  // preheat relay holds until its own time is used up
  a_preheat_hold: assert property (
    r.st == S_PREHEAT && mains_fail_in &&
    r.tmr < 16'(r.regs[`R_START][`F_PREHEAT]) |=> relay_out.preheat)
    else $error("preheat ended early");
  // starter stays off for the whole pause between attempts
  a_wait_hold: assert property (
    r.st == S_WAIT && mains_fail_in &&
    r.tmr < 16'(r.regs[`R_START][`F_WAIT]) |=> !relay_out.crank)
    else $error("crank during wait between starts");
  // band faults need the fail time; only overshoot may skip it
  a_speed_delay: assert property (
    !os_hit && r.spd_t < r.regs[`R_SPD][`F_SPD_FAIL] |->
    !set.lo_warn && !set.lo_sd && !set.hi_warn && !set.hi_sd)
    else $error("speed fault before fail time");
  // a short outage must never reach the fuel solenoid
  a_delay_abort: assert property (
    r.st == S_DELAY && !mains_fail_in |=> r.st == S_IDLE && !relay_out.fuel)
    else $error("start kept after mains return in delay");
  // method 1 keeps the load off while the coolant is still cold
  a_heat_coolant: assert property (
    r.st == S_HEAT && mains_fail_in && !sd_ev && !dump_ev && r.regs[`R_RUN][`F_HEAT_M] &&
    sense_in.coolant_c < 8'(r.regs[`R_RUN][`F_HEAT_C]) |=> !relay_out.load)
    else $error("load taken before coolant warm");
endmodule : engine_seq
`default_nettype wire

//--- engine_seq_cfg.svh
// Purpose: offsets, field positions, reset values and timing for the engine sequencer
// Assumes: 40 MHz system clock, word-aligned register port
// Notes: a register's byte address is four times its index
`ifndef ENGINE_SEQ_CFG_SVH
`define ENGINE_SEQ_CFG_SVH
// ****************************************
// timing
// ****************************************
`define CLK_HZ 40000000
`define TICK_PERIOD_S 1
`define TICK_CYCLES (`TICK_PERIOD_S * `CLK_HZ)
`define SEC_PER_MIN 16'h003c
`define PCT_SCALE 24'h000064
// ****************************************
// register indices
// ****************************************
`define R_NOM1 4'h0
`define R_NOM2 4'h1
`define R_NOM3 4'h2
`define R_LIM 4'h3
`define R_SPD 4'h4
`define R_CHG 4'h5
`define R_START 4'h6
`define R_RUN 4'h7
`define R_STOP 4'h8
`define R_CUT 4'h9
`define R_STAT 4'ha
`define R_ALM 4'hb
`define N_CFG 10
// ****************************************
// field positions
// ****************************************
`define F_RPM 15:0
`define F_LW 7:0
`define F_LS 15:8
`define F_HW 23:16
`define F_HS 31:24
`define F_SPD_FAIL 3:0
`define F_OS 15:8
`define F_LOSS_EN 16
`define F_LOSS_ACT 18:17
`define F_LOSS_T 31:24
`define F_CHG_W 8:0
`define F_CHG_S 24:16
`define F_CHG_T 31:25
`define F_DLY_MIN 9:0
`define F_PREHEAT 14:10
`define F_CRANK 19:16
`define F_NSTART 22:20
`define F_WAIT 31:24
`define F_CHOKE 7:0
`define F_HEAT_T 15:8
`define F_HEAT_C 22:16
`define F_HEAT_M 23
`define F_COOL 9:0
`define F_STOP_T 22:16
// ****************************************
// reset values
// ****************************************
`define RST_NOM1 32'h000005dc
`define RST_NOM2 32'h00000708
`define RST_NOM3 32'h00000708
`define RST_LIM 32'h736e555a
`define RST_SPD 32'h00000a03
`define RST_CHG 32'h0228003c
`define RST_START 32'h0a360001
`define RST_RUN 32'h00000405
`define RST_STOP 32'h000a0078
`define RST_CUT 32'h000001f4
`define LOSS_SD 2'h0
`define LOSS_DUMP 2'h1
`endif

//--- engine_seq_pkg.sv
// Purpose: types shared by the engine sequencer and its bench
// Assumes: nothing beyond the cfg header
// Notes: all sequencer state lives in core_type
`default_nettype none
package engine_seq_pkg;
  // sequencer phases
  typedef enum logic [3:0] {
    S_IDLE, S_DELAY, S_PREHEAT, S_CRANK, S_WAIT, S_HEAT, S_LOADED, S_COOL, S_STOP
  } seq_state_type;
  // engine sensing; charge in tenths of a volt
  typedef struct packed {
    logic [15:0] rpm;
    logic sig_ok;
    logic [8:0] charge_dv;
    logic [7:0] coolant_c;
  } sense_type;
  // relay drives
  typedef struct packed {
    logic fuel;
    logic preheat;
    logic crank;
    logic choke;
    logic stop;
    logic load;
  } relay_type;
  // sticky alarm flags, bit 0 is stop_failure_warning
  typedef struct packed {
    logic lo_warn;
    logic lo_sd;
    logic hi_warn;
    logic hi_sd;
    logic sig_lost;
    logic sig_dump;
    logic chg_warn;
    logic chg_sd;
    logic start_fail;
    logic stop_failure_warning;
  } alarm_type;
  typedef struct packed {
    seq_state_type st;
    logic [31:0] div;
    logic [15:0] tmr;
    logic [7:0] chk;
    logic choke;
    logic [2:0] att;
    logic [3:0] spd_t;
    logic [7:0] loss_t;
    logic [6:0] chg_t;
    alarm_type alm;
    logic [9:0][31:0] regs;
    logic [31:0] rdata;
  } core_type;
endpackage : engine_seq_pkg
`default_nettype wire

//--- engine_plant.sv
// Purpose: engine plant behind the relays: speed pickup and charge alternator
// Assumes: the engine fires on the third crank cycle while fire_in is high
// Notes: stick_in models a jammed stop path, so the engine keeps running
`default_nettype none
module engine_plant
  import engine_seq_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire relay_type relay_in,
  input wire logic fire_in,
  input wire logic stick_in,
  input wire logic sig_lost_in,
  input wire logic [15:0] run_rpm_in,
  input wire logic [8:0] chg_in,
  output sense_type sense_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic running_r;
  logic [1:0] fire_cnt_r;
  // ****************************************
  // combustion
  // ****************************************
  // a fuel cut stops the engine unless the stop path is jammed
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      running_r <= 1'b0;
      fire_cnt_r <= 2'h0;
    end else if (!relay_in.fuel && !stick_in) begin
      running_r <= 1'b0;
      fire_cnt_r <= 2'h0;
    end else if (relay_in.crank && relay_in.fuel && fire_in) begin
      fire_cnt_r <= fire_cnt_r + 2'h1;
      if (fire_cnt_r == 2'h2) begin
        running_r <= 1'b1;
      end
    end
  end
  // starter turns the engine slowly; a stopped engine shows zero speed
  assign sense_out.rpm = running_r ? run_rpm_in : (relay_in.crank ? 16'h00c8 : 16'h0000);
  // a broken pickup wire removes the speed signal while the engine still turns
  assign sense_out.sig_ok = !sig_lost_in;
  assign sense_out.charge_dv = running_r ? chg_in : 9'h000;
  assign sense_out.coolant_c = 8'h32;
endmodule : engine_plant
`default_nettype wire

//--- test_engine_seq.sv
// Purpose: self-checking bench for the engine sequencer
// Assumes: tick shortened to 4 clocks; timers may fire up to one tick early
// Notes: expected flags come from integer limit arithmetic in the bench
`default_nettype none
`include "engine_seq_cfg.svh"
module test_engine_seq
  import engine_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK = 4;
  localparam int FUEL = 5, PRE = 4, CRANK = 3, CHOKE = 2, STOP = 1, LOAD = 0;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic mains = 1'b0;
  logic [1:0] freq_sel = 2'h0;
  logic fire = 1'b0;
  logic stick = 1'b0;
  logic sig_drop = 1'b0;
  logic [15:0] run_rpm = 16'h0000;
  logic [8:0] chg = 9'h08c;
  sense_type sense;
  relay_type relay;
  alarm_type alarm;
  logic [5:0] rb;
  int num_errors = 0;
  int samples_checked = 0;
  logic [31:0] rst_tab [10] = '{`RST_NOM1, `RST_NOM2, `RST_NOM3, `RST_LIM, `RST_SPD,
    `RST_CHG, `RST_START, `RST_RUN, `RST_STOP, `RST_CUT};
  int pct_tab [4] = '{89, 112, 100, 100};
  int chg_tab [4] = '{140, 140, 50, 140};
  int n, n2, nom, r;
  logic [31:0] d;
  logic [9:0] exp_alm;
  assign rb = relay;
  // ****************************************
  // design and plant
  // ****************************************
  engine_seq #(.TICK_CYCLES(TICK)) engine_seq_i (.ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .mains_fail_in(mains), .freq_sel_in(freq_sel),
    .sense_in(sense), .relay_out(relay), .alarm_out(alarm));
  engine_plant engine_plant_i (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .relay_in(relay), .fire_in(fire), .stick_in(stick), .sig_lost_in(sig_drop),
    .run_rpm_in(run_rpm),
    .chg_in(chg), .sense_out(sense));
  // 40 MHz system clock
  always #12.5 ref_clk_in = ~ref_clk_in;
  // ****************************************
  // helpers
  // ****************************************
  task automatic wrap_up();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  // a timer of t ticks may end up to one tick early
  task automatic chk_span(input string name, input int c, input int t);
    samples_checked++;
    if (c < (t - 1) * TICK || c > t * TICK + 2) begin
      num_errors++;
      $display("unexpected %s expected %0d ticks seen %0d cycles", name, t, c);
    end
  endtask : chk_span
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask : bus_wr
  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : bus_rd
  // bounded wait for one relay level, counting cycles
  task automatic wait_bit(input int idx, input logic lvl, output int c);
    c = 0;
    while (rb[idx] !== lvl) begin
      @(posedge ref_clk_in);
      #1 c++;
      if (c > 3000) begin
        num_errors++;
        $display("unexpected relay %0d expected %b seen %b", idx, lvl, rb[idx]);
        wrap_up();
      end
    end
  endtask : wait_bit
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(32'h4645));
    repeat (8) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      bus_rd(8'(i * 4), d);
      chk("reset value", rst_tab[i], d);
    end
    bus_rd(8'h30, d);
    chk("unmapped read", 32'h0, d);
    bus_wr(8'h28, 32'hffffffff);
    bus_rd(8'h28, d);
    chk("status after write", 32'h0, d);
    bus_wr(8'h18, 32'h02230800);
    bus_wr(8'h1c, 32'h00000201);
    bus_wr(8'h20, 32'h00030002);
    bus_wr(8'h10, 32'h00000a01);
    // engine never fires: two attempts, then start failure and stop
    @(posedge ref_clk_in);
    mains <= 1'b1;
    wait_bit(FUEL, 1'b1, n);
    chk("preheat on", 1, rb[PRE]);
    wait_bit(CRANK, 1'b1, n);
    chk_span("preheat", n, 2);
    chk("choke with crank", 1, rb[CHOKE]);
    wait_bit(CHOKE, 1'b0, n);
    chk_span("choke", n, 1);
    wait_bit(CRANK, 1'b0, n2);
    chk_span("crank", n + n2, 3);
    wait_bit(CRANK, 1'b1, n);
    chk_span("wait between", n, 2);
    wait_bit(STOP, 1'b1, n);
    chk("start failure", 10'h002, alarm);
    wait_bit(STOP, 1'b0, n);
    chk_span("stop solenoid", n, 3);
    chk("no stop warning", 10'h002, alarm);
    // engine fires: crank cut, heating, then load
    fire <= 1'b1;
    run_rpm <= 16'd1500;
    bus_wr(8'h2c, 32'h000003ff);
    wait_bit(CRANK, 1'b1, n);
    wait_bit(CRANK, 1'b0, n);
    chk("crank cut", 1, n <= 8);
    chk("choke on running", 0, rb[CHOKE]);
    wait_bit(LOAD, 1'b1, n);
    chk_span("heating", n, 2);
    // speed and charge bands for each nominal selection
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 4; k++) begin
        nom = (s == 0) ? 1500 : 1800;
        r = (k == 3) ? 92 + int'($urandom % 17) : pct_tab[k];
        r = nom * r / 100;
        @(posedge ref_clk_in);
        freq_sel <= 2'(s);
        run_rpm <= 16'(r);
        chg <= 9'(chg_tab[k]);
        repeat (4 * TICK + 4) @(posedge ref_clk_in);
        #1 exp_alm = {r * 100 < nom * 90, r * 100 < nom * 85, r * 100 > nom * 110,
          r * 100 > nom * 115, 2'b00, chg_tab[k] < 60, chg_tab[k] < 40, 2'b00};
        chk("band flags", exp_alm, alarm);
        run_rpm <= 16'(nom);
        chg <= 9'h08c;
        repeat (2) @(posedge ref_clk_in);
        bus_wr(8'h2c, 32'h000003ff);
      end
    end
    // speed signal loss: ignored while its enable bit is off, a plain warning with action 2
    @(posedge ref_clk_in);
    sig_drop <= 1'b1;
    repeat (4 * TICK + 4) @(posedge ref_clk_in);
    #1 chk("loss ignored", 10'h000, alarm);
    bus_wr(8'h10, 32'h01050a01);
    repeat (4 * TICK + 4) @(posedge ref_clk_in);
    #1 chk("loss warning", 10'h020, alarm);
    chk("load kept on warning", 1, rb[LOAD]);
    sig_drop <= 1'b0;
    bus_wr(8'h10, 32'h00000a01);
    bus_wr(8'h2c, 32'h000003ff);
    // mains returns: cooldown, then a clean stop
    @(posedge ref_clk_in);
    mains <= 1'b0;
    wait_bit(LOAD, 1'b0, n);
    wait_bit(STOP, 1'b1, n);
    chk_span("cooldown", n, 2);
    wait_bit(STOP, 1'b0, n);
    chk("clean stop", 10'h000, alarm);
    // overshoot trips at once despite a long fail time; engine will not stop
    bus_wr(8'h10, 32'h00000a0a);
    @(posedge ref_clk_in);
    mains <= 1'b1;
    freq_sel <= 2'h0;
    wait_bit(LOAD, 1'b1, n);
    @(posedge ref_clk_in);
    stick <= 1'b1;
    run_rpm <= 16'd1905;
    wait_bit(STOP, 1'b1, n);
    chk("overshoot delay", 1, n <= 3);
    chk("overshoot flag", 10'h040, alarm);
    wait_bit(STOP, 1'b0, n);
    chk("stop failure", 10'h041, alarm);
    wrap_up();
  end
endmodule : test_engine_seq
`default_nettype wire
